//--- hwm_pkg.sv
// constants, register map and carrier types for the hardware monitor pins
`default_nettype none
package hwm_pkg;
   // ***********************************
   // register offsets
   // ***********************************
   localparam logic [7:0] ADC_RES_BASE = 8'h20;
   localparam logic [7:0] TEMP_MSB_ADDR = 8'h27;
   localparam logic [7:0] TEMP_LSB_ADDR = 8'h28;
   localparam logic [7:0] ADC_LIM_BASE = 8'h2b;
   localparam logic [7:0] TEMP_HI_ADDR = 8'h39;
   localparam logic [7:0] TEMP_CRIT_ADDR = 8'h3a;
   localparam logic [7:0] CFG_ADDR = 8'h40;
   localparam logic [7:0] STATUS_ADDR = 8'h41;
   localparam logic [7:0] MASK_ADDR = 8'h43;
   localparam logic [7:0] CI_CLR_ADDR = 8'h46;
   localparam logic [7:0] TCFG_ADDR = 8'h4b;
   // ***********************************
   // field positions
   // ***********************************
   localparam int CFG_START_BIT = 0;
   localparam int CFG_INT_EN_BIT = 1;
   localparam int CFG_CI_CLR_BIT = 6;
   localparam int CI_CLR_BIT = 7;
   localparam int TCFG_RES12_BIT = 0;
   localparam int TCFG_CRIT_MASK_BIT = 1;
   localparam int ST_TEMP_BIT = 6;
   localparam int ST_INTR_BIT = 7;
   // ***********************************
   // sizes and reset values
   // ***********************************
   localparam int N_ADC = 6;
   localparam int ADC_BITS = 8;
   localparam int TEMP_BITS = 12;
   localparam int TEMP_LOW_BITS = 3;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;
   localparam logic [7:0] TCFG_RST = 8'h00;
   localparam logic [7:0] ADC_LIM_RST = 8'hff;
   localparam logic [7:0] TEMP_HI_RST = 8'h46;
   localparam logic [7:0] TEMP_CRIT_RST = 8'h50;
   localparam logic [4:0] SLAVE_BASE_DEF = 5'h0a;
   // ***********************************
   // timing
   // ***********************************
   localparam int CLK_MHZ = 125;
   localparam int CLR_TIME_US = 20000;
   localparam int CLR_CYC = CLR_TIME_US * CLK_MHZ;
   localparam int CLR_W = $clog2(CLR_CYC + 1);
   // ***********************************
   // carriers
   // ***********************************
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } hwm_wr_s;
   typedef struct packed {
      logic scl;
      logic sda;
   } hwm_smb_s;
endpackage
`default_nettype wire

//--- hwm_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module hwm_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // pins and filtered levels
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

   // change taken once second and third flops agree
   always_comb
   begin
      lvl_d = lvl_q;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s2_q[i] == s3_q[i])
            lvl_d[i] = s3_q[i];
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (reset_i)
         lvl_q <= '0;
      else
         lvl_q <= lvl_d;
   end

   assign level_o = lvl_q;
endmodule // hwm_sync
`default_nettype wire

//--- hwm_smb_slave.sv
// serial two-wire slave: address, pointer, register write and read
`timescale 1ns/10ps
`default_nettype none
module hwm_smb_slave (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // filtered bus levels and own address
   input wire hwm_pkg::hwm_smb_s bus_i,
   input wire logic [6:0] dev_addr_i,
   // register port
   input wire logic [7:0] rd_data_i,
   output hwm_pkg::hwm_wr_s wr_o,
   output logic [7:0] rd_addr_o,
   output logic rd_ack_o,
   // data line drive
   output logic sda_o,
   output logic sda_oe_n_o
);
   typedef enum {S_IDLE, S_RX, S_ACK, S_TX, S_RACK} hwm_smb_st_e;
   hwm_smb_st_e st_q, st_d;
   logic scl_q, sda_q, rw_q, rw_d, first_q, first_d, pset_q, pset_d;
   logic drv_q, drv_d, rdack_q, rdack_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
   hwm_pkg::hwm_wr_s wr_q, wr_d;
   logic rise, fall, start, stop;

   assign rise = bus_i.scl & ~scl_q;
   assign fall = ~bus_i.scl & scl_q;
   assign start = scl_q & bus_i.scl & sda_q & ~bus_i.sda;
   assign stop = scl_q & bus_i.scl & ~sda_q & bus_i.sda;

   // ***********************************
   // byte engine
   // ***********************************
   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      rw_d = rw_q;
      first_d = first_q;
      pset_d = pset_q;
      ptr_d = ptr_q;
      drv_d = drv_q;
      wr_d = '0;
      rdack_d = 1'b0;
      if (start)
      begin
         st_d = S_RX;
         cnt_d = 4'h0;
         first_d = 1'b1;
         pset_d = 1'b0;
         drv_d = 1'b0;
      end
      else if (stop)
      begin
         st_d = S_IDLE;
         drv_d = 1'b0;
      end
      else
      begin
         unique case (st_q)
            S_IDLE: ;
            S_RX:
               if (rise)
               begin
                  sh_d = {sh_q[6:0], bus_i.sda};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (fall && cnt_q == 4'h8)
               begin
                  st_d = S_ACK;
                  drv_d = 1'b1;
                  if (first_q)
                  begin
                     first_d = 1'b0;
                     rw_d = sh_q[0];
                     if (sh_q[7:1] != dev_addr_i)
                     begin
                        st_d = S_IDLE;
                        drv_d = 1'b0;
                     end
                  end
                  else if (!pset_q)
                  begin
                     ptr_d = sh_q;
                     pset_d = 1'b1;
                  end
                  else
                  begin
                     wr_d.en = 1'b1;
                     wr_d.addr = ptr_q;
                     wr_d.data = sh_q;
                     ptr_d = ptr_q + 8'h01;
                  end
               end
            S_ACK:
               if (fall)
               begin
                  cnt_d = 4'h0;
                  st_d = rw_q ? S_TX : S_RX;
                  drv_d = rw_q & ~rd_data_i[7];
                  if (rw_q)
                  begin
                     sh_d = rd_data_i;
                     rdack_d = 1'b1;
                  end
               end
            S_TX:
               if (rise)
                  cnt_d = cnt_q + 4'h1;
               else if (fall && cnt_q == 4'h8)
               begin
                  st_d = S_RACK;
                  drv_d = 1'b0;
               end
               else if (fall)
                  drv_d = ~sh_q[3'h7 - cnt_q[2:0]];
            S_RACK:
               if (rise && bus_i.sda)
                  st_d = S_IDLE;
               else if (rise)
                  ptr_d = ptr_q + 8'h01;
               else if (fall)
               begin
                  st_d = S_TX;
                  cnt_d = 4'h0;
                  sh_d = rd_data_i;
                  rdack_d = 1'b1;
                  drv_d = ~rd_data_i[7];
               end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         st_q <= S_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         pset_q <= 1'b0;
         ptr_q <= 8'h00;
         drv_q <= 1'b0;
         wr_q <= '0;
         rdack_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         scl_q <= bus_i.scl;
         sda_q <= bus_i.sda;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         rw_q <= rw_d;
         first_q <= first_d;
         pset_q <= pset_d;
         ptr_q <= ptr_d;
         drv_q <= drv_d;
         wr_q <= wr_d;
         rdack_q <= rdack_d;
      end
   end

   assign wr_o = wr_q;
   assign rd_addr_o = ptr_q;
   assign rd_ack_o = rdack_q;
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~drv_q;

   a_sda_drive_state: assert property (@(posedge ref_clk_i)
      disable iff (reset_i) !sda_oe_n_o |-> $past(st_q) != S_IDLE)
      else $error("data line driven while idle");
   c_read_byte: cover property (@(posedge ref_clk_i)
      disable iff (reset_i) st_q == S_RACK);
endmodule // hwm_smb_slave
`default_nettype wire

//--- hwm_pin_ctrl.sv
// pin control, limit checking and alarms of the hardware monitor
`timescale 1ns/10ps
`default_nettype none
module hwm_pin_ctrl #(
   parameter int CLR_CYC = hwm_pkg::CLR_CYC,
   parameter logic [4:0] SLAVE_BASE = hwm_pkg::SLAVE_BASE_DEF
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // serial bus
   input wire logic smb_clk_i,
   input wire logic smb_data_i,
   output logic smb_data_o,
   output logic smb_data_oe_n_o,
   // address straps and test
   input wire logic addr_strap_low_i,
   output logic addr_strap_low_o,
   output logic addr_strap_low_oe_n_o,
   input wire logic addr_strap_high_i,
   input wire logic connectivity_test_mode_in_i,
   // chassis intrusion
   input wire logic chassis_intrusion_line_i,
   output logic chassis_intrusion_line_o,
   output logic chassis_intrusion_line_oe_n_o,
   // alarms
   output logic int_n_o,
   output logic int_oe_n_o,
   output logic critical_temp_alarm_n_o,
   output logic critical_temp_alarm_oe_n_o,
   // converter results
   input wire logic [hwm_pkg::TEMP_BITS-1:0] temp_result_i,
   input wire logic temp_valid_i,
   input wire logic [hwm_pkg::N_ADC*hwm_pkg::ADC_BITS-1:0] adc_result_i,
   input wire logic adc_valid_i
);
   localparam int NA = hwm_pkg::N_ADC;
   localparam int CW = hwm_pkg::CLR_W;

   // ***********************************
   // pin sampling and serial slave
   // ***********************************
   logic [5:0] lvl;
   logic s_scl, s_sda, s_lo, s_hi, s_test, s_ci;
   hwm_pkg::hwm_wr_s wr;
   logic [7:0] rd_addr, rd_data;
   logic rd_ack;
   logic [6:0] dev_addr;

   hwm_sync #(
      .WIDTH(6)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .pin_i({smb_clk_i, smb_data_i, addr_strap_low_i, addr_strap_high_i,
              connectivity_test_mode_in_i, chassis_intrusion_line_i}),
      .level_o(lvl)
   );
   assign {s_scl, s_sda, s_lo, s_hi, s_test, s_ci} = lvl;

   hwm_smb_slave u_slave (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .bus_i('{scl: s_scl, sda: s_sda}),
      .dev_addr_i(dev_addr),
      .rd_data_i(rd_data),
      .wr_o(wr),
      .rd_addr_o(rd_addr),
      .rd_ack_o(rd_ack),
      .sda_o(smb_data_o),
      .sda_oe_n_o(smb_data_oe_n_o)
   );

   function automatic logic lim_hit(input logic [7:0] a);
      lim_hit = a >= hwm_pkg::ADC_LIM_BASE &&
                a < hwm_pkg::ADC_LIM_BASE + 8'(NA);
   endfunction

   function automatic logic res_hit(input logic [7:0] a);
      res_hit = a >= hwm_pkg::ADC_RES_BASE &&
                a < hwm_pkg::ADC_RES_BASE + 8'(NA);
   endfunction

   // ***********************************
   // register file
   // ***********************************
   logic [7:0] cfg_q, cfg_d, mask_q, mask_d, tcfg_q, tcfg_d;
   logic [7:0] status_q, status_d, hi_q, hi_d, crit_q, crit_d;
   logic [6:0] ciclr_q, ciclr_d;
   logic [7:0] lim_q [NA];
   logic [7:0] lim_d [NA];
   logic [CW-1:0] clr_q, clr_d;
   logic busy, clr_start, st_rd;
   logic [7:0] viol;
   logic [7:0] adc_q [NA];
   logic [7:0] adc_d [NA];
   logic [11:0] temp_q, temp_d;

   assign busy = clr_q != '0;
   assign st_rd = rd_ack && rd_addr == hwm_pkg::STATUS_ADDR;
   assign clr_start = !busy && wr.en &&
      ((wr.addr == hwm_pkg::CFG_ADDR && wr.data[hwm_pkg::CFG_CI_CLR_BIT]) ||
       (wr.addr == hwm_pkg::CI_CLR_ADDR && wr.data[hwm_pkg::CI_CLR_BIT]));

   always_comb
   begin
      viol = 8'h00;
      for (int i = 0; i < NA; i++)
         viol[i] = adc_q[i] > lim_q[i];
      viol[hwm_pkg::ST_TEMP_BIT] =
         $signed(temp_q[11:4]) > $signed(hi_q);
      viol = viol & {8{cfg_q[hwm_pkg::CFG_START_BIT]}};
   end

   always_comb
   begin
      cfg_d = cfg_q;
      mask_d = mask_q;
      tcfg_d = tcfg_q;
      hi_d = hi_q;
      crit_d = crit_q;
      ciclr_d = ciclr_q;
      lim_d = lim_q;
      clr_d = busy ? clr_q - CW'(1) : clr_q;
      if (clr_start)
         clr_d = CW'(CLR_CYC);
      if (wr.en)
      begin
         unique case (wr.addr)
            hwm_pkg::CFG_ADDR:
            begin
               cfg_d = wr.data;
               cfg_d[hwm_pkg::CFG_CI_CLR_BIT] = 1'b0;
            end
            hwm_pkg::MASK_ADDR: mask_d = wr.data;
            hwm_pkg::TCFG_ADDR: tcfg_d = wr.data;
            hwm_pkg::TEMP_HI_ADDR: hi_d = wr.data;
            hwm_pkg::TEMP_CRIT_ADDR: crit_d = wr.data;
            hwm_pkg::CI_CLR_ADDR: ciclr_d = wr.data[6:0];
            default:
               if (lim_hit(wr.addr))
                  lim_d[3'(wr.addr - hwm_pkg::ADC_LIM_BASE)] = wr.data;
         endcase
      end
      // sticky flags: a new event beats a clear in the same cycle
      status_d = (status_q & ~{1'b0, {7{st_rd}}}) | viol;
      status_d[hwm_pkg::ST_INTR_BIT] =
         (status_q[hwm_pkg::ST_INTR_BIT] & ~clr_start) | (s_ci & ~busy);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         cfg_q <= hwm_pkg::CFG_RST;
         mask_q <= hwm_pkg::MASK_RST;
         tcfg_q <= hwm_pkg::TCFG_RST;
         hi_q <= hwm_pkg::TEMP_HI_RST;
         crit_q <= hwm_pkg::TEMP_CRIT_RST;
         ciclr_q <= 7'h00;
         status_q <= 8'h00;
         clr_q <= '0;
         for (int i = 0; i < NA; i++)
            lim_q[i] <= hwm_pkg::ADC_LIM_RST;
      end
      else
      begin
         cfg_q <= cfg_d;
         mask_q <= mask_d;
         tcfg_q <= tcfg_d;
         hi_q <= hi_d;
         crit_q <= crit_d;
         ciclr_q <= ciclr_d;
         status_q <= status_d;
         clr_q <= clr_d;
         lim_q <= lim_d;
      end
   end

   // read mux
   always_comb
   begin
      rd_data = 8'h00;
      unique case (rd_addr)
         hwm_pkg::CFG_ADDR: rd_data = cfg_q | {1'b0, busy, 6'h00};
         hwm_pkg::STATUS_ADDR: rd_data = status_q;
         hwm_pkg::MASK_ADDR: rd_data = mask_q;
         hwm_pkg::TCFG_ADDR: rd_data = tcfg_q;
         hwm_pkg::TEMP_HI_ADDR: rd_data = hi_q;
         hwm_pkg::TEMP_CRIT_ADDR: rd_data = crit_q;
         hwm_pkg::CI_CLR_ADDR: rd_data = {busy, ciclr_q};
         hwm_pkg::TEMP_MSB_ADDR: rd_data = temp_q[11:4];
         hwm_pkg::TEMP_LSB_ADDR: rd_data = {temp_q[3:0], 4'h0};
         default:
            if (res_hit(rd_addr))
               rd_data = adc_q[3'(rd_addr - hwm_pkg::ADC_RES_BASE)];
            else if (lim_hit(rd_addr))
               rd_data = lim_q[3'(rd_addr - hwm_pkg::ADC_LIM_BASE)];
      endcase
   end

   // ***********************************
   // results, straps and alarm pins
   // ***********************************
   logic [1:0] strap_q, strap_d;
   logic test_q, nand_q, nand_d, int_q, int_d, tcrit_q, tcrit_d;

   always_comb
   begin
      adc_d = adc_q;
      temp_d = temp_q;
      if (adc_valid_i)
         for (int i = 0; i < NA; i++)
            adc_d[i] = adc_result_i[i*8 +: 8];
      if (temp_valid_i)
      begin
         temp_d = temp_result_i;
         if (!tcfg_q[hwm_pkg::TCFG_RES12_BIT])
            temp_d[hwm_pkg::TEMP_LOW_BITS-1:0] = '0;
      end
      strap_d = test_q ? strap_q : {s_hi, s_lo};
      nand_d = ~(s_hi & s_scl);
      nand_d = ~(nand_d & s_sda);
      nand_d = ~(nand_d & s_ci);
      int_d = cfg_q[hwm_pkg::CFG_INT_EN_BIT] && |(status_q & ~mask_q);
      tcrit_d = cfg_q[hwm_pkg::CFG_START_BIT] &&
         !tcfg_q[hwm_pkg::TCFG_CRIT_MASK_BIT] &&
         $signed(temp_q[11:4]) >= $signed(crit_q);
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         temp_q <= 12'h000;
         strap_q <= 2'h0;
         test_q <= 1'b0;
         nand_q <= 1'b1;
         int_q <= 1'b0;
         tcrit_q <= 1'b0;
         for (int i = 0; i < NA; i++)
            adc_q[i] <= 8'h00;
      end
      else
      begin
         adc_q <= adc_d;
         temp_q <= temp_d;
         strap_q <= strap_d;
         test_q <= s_test;
         nand_q <= nand_d;
         int_q <= int_d;
         tcrit_q <= tcrit_d;
      end
   end

   assign dev_addr = {SLAVE_BASE, strap_q};
   assign addr_strap_low_o = nand_q;
   assign addr_strap_low_oe_n_o = ~test_q;
   assign chassis_intrusion_line_o = 1'b0;
   assign chassis_intrusion_line_oe_n_o = ~busy;
   assign int_n_o = 1'b0;
   assign int_oe_n_o = ~int_q;
   assign critical_temp_alarm_n_o = 1'b0;
   assign critical_temp_alarm_oe_n_o = ~tcrit_q;

   // ***********************************
   // checks
   // ***********************************
   logic [CW-1:0] len_q;
   always_ff @(posedge ref_clk_i)
      len_q <= (reset_i || !busy) ? '0 : len_q + CW'(1);

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   a_addr_low_bit: assert property (
      !test_q |=> dev_addr[0] == $past(s_lo))
      else $error("address bit 0 not from low strap");
   a_addr_high_bit: assert property (
      !test_q |=> dev_addr[1] == $past(s_hi))
      else $error("address bit 1 not from high strap");
   a_test_drive_strap: assert property (
      test_q |-> !addr_strap_low_oe_n_o && addr_strap_low_o == !($past(s_ci)
      && !($past(s_sda) && !($past(s_hi) && $past(s_scl)))))
      else $error("strap not driven in test mode");
   a_intr_latch_set: assert property (
      s_ci && !busy |=> status_q[hwm_pkg::ST_INTR_BIT])
      else $error("intrusion not latched");
   a_clear_pulse_len: assert property (
      $fell(busy) |-> $past(len_q) == CW'(CLR_CYC - 1))
      else $error("clear pulse length wrong");
   a_clear_drives_low: assert property (
      clr_start |=> !chassis_intrusion_line_oe_n_o [*8])
      else $error("clear pulse not driven");
   a_int_enable_gate: assert property (
      !cfg_q[hwm_pkg::CFG_INT_EN_BIT] |=> int_oe_n_o)
      else $error("interrupt driven while disabled");
   a_crit_alarm_set: assert property (
      cfg_q[0] && !tcfg_q[1] && $signed(temp_q[11:4]) >= $signed(crit_q)
      |=> !critical_temp_alarm_oe_n_o)
      else $error("critical alarm missing");
   a_viol_to_int: assert property (
      !wr.en && cfg_q[1] && (viol & ~mask_q) != 8'h00
      |=> ##1 !int_oe_n_o)
      else $error("violation did not raise interrupt");
   a_temp_nine_bit: assert property (
      temp_valid_i && !tcfg_q[0] |=> temp_q[2:0] == 3'h0)
      else $error("low temperature bits kept at 9 bits");
   a_adc_capture: assert property (
      adc_valid_i |=> adc_q[NA-1] == $past(adc_result_i[47:40]))
      else $error("converter result not captured");
   a_test_entry: assert property (
      $rose(s_test) |=> ##1 !addr_strap_low_oe_n_o)
      else $error("test mode not entered");
   a_intr_sticky: assert property (
      status_q[hwm_pkg::ST_INTR_BIT] && !clr_start
      |=> status_q[hwm_pkg::ST_INTR_BIT])
      else $error("intrusion latch lost");

   c_clear_done: cover property ($fell(busy));
   c_test_mode: cover property ($rose(test_q));
   c_crit_alarm: cover property (!critical_temp_alarm_oe_n_o);
   c_int_out: cover property (!int_oe_n_o);
endmodule // hwm_pin_ctrl
`default_nettype wire

//--- hwm_host.sv
// serial bus host model for the hardware monitor bench
`timescale 1ns/10ps
`default_nettype none
module hwm_host (
   // clock and line level
   input wire logic clk_i,
   input wire logic sda_i,
   // host drive
   output logic scl_o,
   output logic sda_low_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic bit_x(input logic b, output logic r);
      wt(5);
      sda_low_o <= !b;
      wt(5);
      scl_o <= 1'b1;
      wt(10);
      r = sda_i;
      scl_o <= 1'b0;
   endtask
   task automatic start;
      wt(5);
      sda_low_o <= 1'b0;
      wt(5);
      scl_o <= 1'b1;
      wt(10);
      sda_low_o <= 1'b1;
      wt(10);
      scl_o <= 1'b0;
   endtask
   task automatic stop;
      wt(5);
      sda_low_o <= 1'b1;
      wt(5);
      scl_o <= 1'b1;
      wt(10);
      sda_low_o <= 1'b0;
      wt(10);
   endtask
   task automatic tx(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = !r;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p,
                     input logic [7:0] d, output logic ok);
      logic k0, k1, k2;
      start();
      tx({a, 1'b0}, k0);
      tx(p, k1);
      tx(d, k2);
      stop();
      ok = k0 & k1 & k2;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] p,
                     output logic [7:0] d, output logic ok);
      logic k0, k1, k2, r;
      start();
      tx({a, 1'b0}, k0);
      tx(p, k1);
      start();
      tx({a, 1'b1}, k2);
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(1'b1, r);
      stop();
      ok = k0 & k1 & k2;
   endtask
endmodule // hwm_host
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the hardware monitor pin control
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
 $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb_top;
   localparam int CLR = 50;
   logic ref_clk_i = 1'b0, reset_i = 1'b1, strap_l = 1'b0, strap_h = 1'b0;
   logic test_mode = 1'b0, ci_drv = 1'b0, temp_v = 1'b0, adc_v = 1'b0;
   logic [11:0] temp = 12'h000;
   logic [47:0] adc = 48'h0;
   logic scl, sda_low, sd_oe_n, al_o, al_oe_n, ci_oe_n, int_oe_n, cr_oe_n, ok;
   logic sd_o, ci_o, int_o, cr_o;
   logic [6:0] dev;
   logic [31:0] v;
   int n_errors = 0, checks = 0, cyc = 0, run = 0, run_len = 0;
   wire logic sda = !(sda_low | !sd_oe_n);
   wire logic al_line = al_oe_n ? strap_l : al_o;
   wire logic ci_line = ci_oe_n ? ci_drv : ci_o;
   hwm_host u_hwm_host (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_low_o(sda_low));
   hwm_pin_ctrl #(.CLR_CYC(CLR)) u_hwm_pin_ctrl (.ref_clk_i(ref_clk_i),
      .reset_i(reset_i), .smb_clk_i(scl), .smb_data_i(sda), .smb_data_o(sd_o),
      .smb_data_oe_n_o(sd_oe_n), .addr_strap_low_i(al_line),
      .addr_strap_low_o(al_o), .addr_strap_low_oe_n_o(al_oe_n),
      .addr_strap_high_i(strap_h), .connectivity_test_mode_in_i(test_mode),
      .chassis_intrusion_line_i(ci_line), .chassis_intrusion_line_o(ci_o),
      .chassis_intrusion_line_oe_n_o(ci_oe_n), .int_n_o(int_o),
      .int_oe_n_o(int_oe_n), .critical_temp_alarm_n_o(cr_o),
      .critical_temp_alarm_oe_n_o(cr_oe_n), .temp_result_i(temp),
      .temp_valid_i(temp_v), .adc_result_i(adc), .adc_valid_i(adc_v));
   always #4 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (!ci_oe_n) run++;
      else if (run != 0)
      begin
         run_len = run;
         run = 0;
      end
      if (cyc == 60000)
      begin
         n_errors++;
         stop_test();
      end
   end
   function automatic logic [7:0] t_lsb(input logic [11:0] t, input int m);
      return m ? {t[3:0], 4'h0} : {t[3], 7'h00};
   endfunction
   // p = {high strap, bus clock, bus data, intrusion line}
   function automatic logic nand_chain(input logic [3:0] p);
      return !(p[0] && !(p[1] && !(p[3] && p[2])));
   endfunction
   task automatic stop_test;
      $display("counts: %0d checks, %0d mismatches", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask
   task automatic w(input logic [7:0] p, input logic [7:0] d);
      u_hwm_host.wr(dev, p, d, ok);
      `CHK(ok, 1'b1)
   endtask
   task automatic r(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      u_hwm_host.rd(dev, p, d, ok);
      `CHK({ok, d}, {1'b1, e})
   endtask
   task automatic cap(input logic [11:0] t, input logic [47:0] a);
      temp <= t;
      adc <= a;
      temp_v <= 1'b1;
      adc_v <= 1'b1;
      wt(1);
      temp_v <= 1'b0;
      adc_v <= 1'b0;
      wt(2);
   endtask
   initial
   begin
      void'($urandom(61));
      wt(3);
      reset_i <= 1'b0;
      wt(8);
      `CHK({int_oe_n, ci_oe_n, cr_oe_n}, 3'b111)
      `CHK({sd_oe_n, sd_o, ci_o, int_o, cr_o}, 5'h10)
      for (int k = 0; k < 4; k++)
      begin
         strap_h <= k[1];
         strap_l <= k[0];
         wt(10);
         dev = {hwm_pkg::SLAVE_BASE_DEF, k[1:0]};
         v = $urandom;
         w(hwm_pkg::MASK_ADDR, v[7:0]);
         r(hwm_pkg::MASK_ADDR, v[7:0]);
         u_hwm_host.wr(dev ^ 7'h03, hwm_pkg::MASK_ADDR, 8'h00, ok);
         `CHK(ok, 1'b0)
      end
      w(hwm_pkg::MASK_ADDR, 8'h00);
      $display("address straps done");
      cap(12'h100, 48'({$urandom, $urandom}));
      for (int i = 0; i < 6; i++)
         r(hwm_pkg::ADC_RES_BASE + 8'(i), adc[8*i +: 8]);
      for (int m = 0; m < 2; m++)
      begin
         w(hwm_pkg::TCFG_ADDR, 8'(m));
         v = $urandom;
         cap(v[11:0], adc);
         r(hwm_pkg::TEMP_MSB_ADDR, v[11:4]);
         r(hwm_pkg::TEMP_LSB_ADDR, t_lsb(v[11:0], m));
      end
      $display("results done");
      for (int k = 0; k < 2; k++)
      begin
         ci_drv <= 1'b1;
         wt(10);
         ci_drv <= 1'b0;
         wt(10);
         r(hwm_pkg::STATUS_ADDR, 8'h80);
         run_len = 0;
         if (k == 0) w(hwm_pkg::CI_CLR_ADDR, 8'h80);
         else w(hwm_pkg::CFG_ADDR, 8'h40);
         wt(100);
         `CHK(run_len, CLR)
         r(hwm_pkg::STATUS_ADDR, 8'h00);
      end
      $display("intrusion done");
      w(hwm_pkg::TCFG_ADDR, 8'h00);
      w(hwm_pkg::ADC_LIM_BASE, 8'h10);
      cap(12'h100, 48'h80);
      w(hwm_pkg::CFG_ADDR, 8'h01);
      wt(20);
      `CHK(int_oe_n, 1'b1)
      w(hwm_pkg::CFG_ADDR, 8'h03);
      wt(5);
      `CHK(int_oe_n, 1'b0)
      w(hwm_pkg::MASK_ADDR, 8'h01);
      wt(5);
      `CHK(int_oe_n, 1'b1)
      cap(12'h4f0, 48'h80);
      `CHK(cr_oe_n, 1'b1)
      r(hwm_pkg::STATUS_ADDR, 8'h41);
      cap(12'h500, 48'h80);
      `CHK(cr_oe_n, 1'b0)
      w(hwm_pkg::TCFG_ADDR, 8'h02);
      wt(5);
      `CHK(cr_oe_n, 1'b1)
      $display("alarms done");
      for (int k = 0; k < 4; k++)
      begin
         v = $urandom;
         strap_h <= v[0];
         ci_drv <= v[1];
         test_mode <= 1'b1;
         wt(8);
         `CHK(al_oe_n, 1'b0)
         `CHK(al_o, nand_chain({strap_h, scl, sda, ci_line}))
      end
      test_mode <= 1'b0;
      ci_drv <= 1'b0;
      wt(8);
      `CHK(al_oe_n, 1'b1)
      $display("test mode done");
      stop_test();
   end
endmodule // tb_top
`default_nettype wire
